//--- rtl/aoss_pkg.sv
`default_nettype none
package aoss_pkg;
  // *************************************************************
  // timing
  // *************************************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int unsigned TICK_W = 27;
  localparam int unsigned DELAY_W = 12;
  localparam logic [11:0] DELAY_MAX_S = 12'hfa0;
  localparam logic [11:0] DELAY_RST = 12'h000;
  localparam logic [15:0] COOL_RST_S = 16'h0000;
  // *************************************************************
  // register map, word addresses
  // *************************************************************
  localparam logic [3:0] ADDR_DELAY = 4'h0;
  localparam logic [3:0] ADDR_COOL = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_REMAIN = 4'h3;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_ENGINE_BIT = 2;
  localparam int unsigned ST_LOADOK_BIT = 3;
  localparam int unsigned ST_REQ_BIT = 4;
  localparam int unsigned ST_INH_BIT = 5;
  localparam int unsigned CTRL_AUTOSTART_BIT = 0;

  typedef enum logic [1:0] {
    AOSS_AUTO = 2'b00,
    AOSS_DELAY = 2'b01,
    AOSS_REMOTE = 2'b10,
    AOSS_COOL = 2'b11
  } aoss_state_t;
endpackage
`default_nettype wire

//--- rtl/aoss_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries the one-second enable from the timebase to the sequencer
interface aoss_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface
`default_nettype wire

//--- rtl/aoss_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module aoss_timebase (
  input wire logic clk_in,
  input wire logic rst_n_in,
  aoss_tick_if.src tick_if
);
  logic [aoss_pkg::TICK_W-1:0] cnt_ff;
  logic [aoss_pkg::TICK_W-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  // free-running divider, one pulse per second
  always_comb
  begin
    nxt_tick = (cnt_ff == aoss_pkg::TICK_W'(aoss_pkg::TICK_CYCLES - 1));
    nxt_cnt = nxt_tick ? '0 : cnt_ff + 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_if.tick = tick_ff;
endmodule // aoss_timebase
`default_nettype wire

//--- rtl/aoss_top.sv
// Summary of operation
// R1: start request waits configured delay, up to 4000s
// R2: both inputs idle: auto mode, inhibit ignored
// R3: no start during delay, inhibit ignored
// R4: remaining delay seconds shown in status
// R5: delay expired with request: remote start engine
// R6: in remote start, inhibit blocks load transfer
// R7: inhibit released while running: allow load transfer
// R8: inputs released: back to auto, cooled stop
// R9: inhibit blocks load even for automatic starts; code lets load through while the delay runs
// R10: detector holds both signals until mains return
// R11: request from NO, inhibit from NC contact
// R12: inhibit asserted from idle, before any remote start
// R13: request dropped early: abandon start, clear count
`timescale 1ns/1ps
`default_nettype none
module aoss_top (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic remote_start_request_in,
  input wire logic load_take_inhibit_in,
  input wire logic auto_start_cause_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  output logic engine_run_out,
  output logic load_transfer_ok_out,
  output logic remote_mode_out
);
  // *************************************************************
  // reset release and pin synchronisers
  // *************************************************************
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [1:0] req_sync_ff;
  logic [1:0] inh_sync_ff;
  logic req;
  logic inh;

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rst_sync_ff <= 2'b00;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // request and inhibit pins are asynchronous to the clock, two stages each
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_sync_ff <= 2'b00;
      inh_sync_ff <= 2'b00;
    end
    else
    begin
      req_sync_ff <= {req_sync_ff[0], remote_start_request_in};
      inh_sync_ff <= {inh_sync_ff[0], load_take_inhibit_in};
    end
  end
  assign req = req_sync_ff[1];
  assign inh = inh_sync_ff[1];

  // *************************************************************
  // timebase
  // *************************************************************
  aoss_tick_if tick_if ();
  aoss_timebase u_timebase (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .tick_if(tick_if)
  );

  // *************************************************************
  // registers
  // *************************************************************
  logic [11:0] delay_cfg_ff;
  logic [11:0] nxt_delay_cfg;
  logic [15:0] cool_cfg_ff;
  logic [15:0] nxt_cool_cfg;
  logic autostart_en_ff;
  logic nxt_autostart_en;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;

  // sequencer state
  aoss_pkg::aoss_state_t state_ff;
  aoss_pkg::aoss_state_t nxt_state;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic engine_ff;
  logic nxt_engine;
  logic load_ok_ff;
  logic nxt_load_ok;
  logic remote_ff;
  logic nxt_remote;
  logic auto_cause;

  // register writes; delay above the limit saturates at 4000 s
  always_comb
  begin
    nxt_delay_cfg = delay_cfg_ff;
    nxt_cool_cfg = cool_cfg_ff;
    nxt_autostart_en = autostart_en_ff;
    if (wr_in)
    begin
      if (addr_in == aoss_pkg::ADDR_DELAY)
        nxt_delay_cfg = (wdata_in > 16'(aoss_pkg::DELAY_MAX_S)) ? aoss_pkg::DELAY_MAX_S
                        : wdata_in[11:0]; // [R1]
      else if (addr_in == aoss_pkg::ADDR_COOL)
        nxt_cool_cfg = wdata_in;
      else if (addr_in == aoss_pkg::ADDR_CTRL)
        nxt_autostart_en = wdata_in[aoss_pkg::CTRL_AUTOSTART_BIT];
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (rd_in)
    begin
      if (addr_in == aoss_pkg::ADDR_DELAY)
        nxt_rdata = {4'h0, delay_cfg_ff};
      else if (addr_in == aoss_pkg::ADDR_COOL)
        nxt_rdata = cool_cfg_ff;
      else if (addr_in == aoss_pkg::ADDR_STATUS)
        nxt_rdata = {10'h000, inh, req, load_ok_ff, engine_ff, state_ff};
      else if (addr_in == aoss_pkg::ADDR_REMAIN)
        nxt_rdata = (state_ff == aoss_pkg::AOSS_DELAY) ? cnt_ff : 16'h0000; // [R4]
      else if (addr_in == aoss_pkg::ADDR_CTRL)
        nxt_rdata = {15'h0000, autostart_en_ff};
      else
        nxt_rdata = 16'h0000;
    end
    else
      nxt_rdata = 16'h0000;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      delay_cfg_ff <= aoss_pkg::DELAY_RST;
      cool_cfg_ff <= aoss_pkg::COOL_RST_S;
      autostart_en_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end
    else
    begin
      delay_cfg_ff <= nxt_delay_cfg;
      cool_cfg_ff <= nxt_cool_cfg;
      autostart_en_ff <= nxt_autostart_en;
      rdata_ff <= nxt_rdata;
    end
  end

  // *************************************************************
  // sequencer
  // *************************************************************
  assign auto_cause = autostart_en_ff & auto_start_cause_in;

  // engine also runs for other automatic causes; inhibit gates load except while the delay runs
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_engine = engine_ff;
    nxt_remote = remote_ff;
    case (state_ff)
      aoss_pkg::AOSS_AUTO:
      begin
        nxt_remote = 1'b0;
        nxt_engine = auto_cause;
        if (req)
        begin
          // inhibit not looked at while waiting [R2] [R3]
          nxt_state = aoss_pkg::AOSS_DELAY;
          nxt_cnt = {4'h0, delay_cfg_ff}; // [R1]
        end
      end
      aoss_pkg::AOSS_DELAY:
      begin
        if (!req)
        begin
          nxt_state = aoss_pkg::AOSS_AUTO; // [R13]
          nxt_cnt = 16'h0000;
        end
        else if (cnt_ff == 16'h0000)
        begin
          nxt_state = aoss_pkg::AOSS_REMOTE; // [R5]
          nxt_engine = 1'b1;
          nxt_remote = 1'b1;
        end
        else if (tick_if.tick)
          nxt_cnt = cnt_ff - 16'h0001; // [R3] [R4]
      end
      aoss_pkg::AOSS_REMOTE:
      begin
        nxt_engine = 1'b1;
        if (!req) // inhibit contact closes again on mains return, so only the request decides
        begin
          nxt_state = aoss_pkg::AOSS_COOL; // [R8]
          nxt_remote = 1'b0;
          nxt_cnt = cool_cfg_ff;
        end
      end
      default:
      begin
        // cooling run before the stop; a new request restarts the delay
        if (req)
        begin
          nxt_state = aoss_pkg::AOSS_DELAY;
          nxt_cnt = {4'h0, delay_cfg_ff};
        end
        else if (cnt_ff == 16'h0000)
        begin
          nxt_state = aoss_pkg::AOSS_AUTO;
          nxt_engine = auto_cause; // [R8]
        end
        else if (tick_if.tick)
          nxt_cnt = cnt_ff - 16'h0001;
      end
    endcase
    // load may go on only with engine running and not cooling; inhibit blocks it except while the delay runs [R6] [R7] [R9]
    nxt_load_ok = nxt_engine && !(inh && (state_ff != aoss_pkg::AOSS_DELAY))
                  && (nxt_state != aoss_pkg::AOSS_COOL) && !(inh && nxt_remote);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= aoss_pkg::AOSS_AUTO;
      cnt_ff <= 16'h0000;
      engine_ff <= 1'b0;
      load_ok_ff <= 1'b0;
      remote_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      engine_ff <= nxt_engine;
      load_ok_ff <= nxt_load_ok;
      remote_ff <= nxt_remote;
    end
  end

  assign rdata_out = rdata_ff;
  assign engine_run_out = engine_ff;
  assign load_transfer_ok_out = load_ok_ff;
  assign remote_mode_out = remote_ff;

  // *************************************************************
  // assertions
  // *************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  delay_limit_a: assert property (delay_cfg_ff <= aoss_pkg::DELAY_MAX_S) // [R1]
    else $error("delay setting above limit");
  idle_auto_a: assert property ((state_ff == aoss_pkg::AOSS_AUTO && !req) // [R2]
    |=> state_ff == aoss_pkg::AOSS_AUTO && !remote_ff)
    else $error("left auto without request");
  no_early_a: assert property ((state_ff == aoss_pkg::AOSS_DELAY && cnt_ff != 16'h0000) |=> !remote_ff) // [R3]
    else $error("remote start before delay expired");
  remain_dec_a: assert property ((state_ff == aoss_pkg::AOSS_DELAY && req && tick_if.tick // [R4]
    && cnt_ff != 16'h0000) |=> cnt_ff == $past(cnt_ff) - 16'h0001)
    else $error("remaining time not counting down");
  start_a: assert property ((state_ff == aoss_pkg::AOSS_DELAY && req && cnt_ff == 16'h0000) // [R5]
    |=> remote_ff && engine_ff && state_ff == aoss_pkg::AOSS_REMOTE)
    else $error("engine not started after delay");
  inhibit_a: assert property ((state_ff == aoss_pkg::AOSS_REMOTE && inh) |=> !load_ok_ff) // [R6]
    else $error("load allowed while inhibited");
  release_a: assert property ((state_ff == aoss_pkg::AOSS_REMOTE && req && !inh) ##1 // [R7]
    (state_ff == aoss_pkg::AOSS_REMOTE && req && !inh) |=> load_ok_ff)
    else $error("load not allowed after release");
  return_a: assert property ((state_ff == aoss_pkg::AOSS_REMOTE && !req) // [R8]
    |=> state_ff == aoss_pkg::AOSS_COOL && engine_ff && !remote_ff)
    else $error("no cooled stop on mains return");
  any_start_a: assert property ((inh && state_ff == aoss_pkg::AOSS_AUTO) |=> !load_ok_ff) // [R9]
    else $error("load allowed on auto start while inhibited");
  abandon_a: assert property ((state_ff == aoss_pkg::AOSS_DELAY && !req) // [R13]
    |=> state_ff == aoss_pkg::AOSS_AUTO && cnt_ff == 16'h0000)
    else $error("pending start not abandoned");

  delay_c: cover property (state_ff == aoss_pkg::AOSS_DELAY ##1 state_ff == aoss_pkg::AOSS_REMOTE);
  load_c: cover property (state_ff == aoss_pkg::AOSS_REMOTE && load_ok_ff);
  cool_c: cover property (state_ff == aoss_pkg::AOSS_COOL ##1 state_ff == aoss_pkg::AOSS_AUTO);
  abort_c: cover property (state_ff == aoss_pkg::AOSS_DELAY ##1 state_ff == aoss_pkg::AOSS_AUTO);
endmodule // aoss_top
`default_nettype wire

//--- test/aoss_detector.sv
`timescale 1ns/1ps
`default_nettype none
// relay contacts of the outage detector; the bench holds the two warnings
module aoss_detector (
  input wire logic early_in,
  input wire logic late_in,
  output logic start_req_out,
  output logic inhibit_out
);
  // early warning through its normally open contact
  assign start_req_out = early_in;
  // late warning through its normally closed contact, so inhibit stands until late rises
  assign inhibit_out = ~late_in;
endmodule // aoss_detector
`default_nettype wire

//--- test/advance_outage_start_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module advance_outage_start_sequencer_tb;
  typedef struct {logic [3:0] a; logic [15:0] w; logic [15:0] e;} aoss_row_t;
  logic clk, rst_n, early, late, cause, wr, rd, eng, load_ok, remote, req, inh;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, d;
  int n_fail, num_checks, cyc;
  aoss_row_t rows [8];

  aoss_top uut (.sys_clk_in(clk), .rst_n_in(rst_n), .remote_start_request_in(req),
    .load_take_inhibit_in(inh), .auto_start_cause_in(cause), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .engine_run_out(eng),
    .load_transfer_ok_out(load_ok), .remote_mode_out(remote));
  aoss_detector det (.early_in(early), .late_in(late), .start_req_out(req), .inhibit_out(inh));

  // ************************************************************
  // clock, timeout and helpers
  // ************************************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail = n_fail + 1;
      wrap_up();
    end
  end

  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // strobe released one edge later, so back-to-back calls never collide
  task wr_reg(input logic [3:0] a, input logic [15:0] w);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= w;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task st(input logic [1:0] e);
    rd_reg(aoss_pkg::ADDR_STATUS, d);
    chk("state", {14'h0000, e}, d & 16'h0003);
  endtask

  // warnings change after an edge, then the synchronisers get time to settle
  task pins(input logic a, input logic b);
    @(posedge clk);
    early <= a;
    late <= b;
    repeat (10) @(posedge clk);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    n_fail = 0;
    num_checks = 0;
    cyc = 0;
    {rst_n, early, late, cause, wr, rd, addr, wdata} = '0;
    rows = '{'{aoss_pkg::ADDR_DELAY, 16'h0064, 16'h0064}, '{aoss_pkg::ADDR_DELAY, 16'h0fa0, 16'h0fa0},
      '{aoss_pkg::ADDR_DELAY, 16'h0fa1, 16'h0fa0}, '{aoss_pkg::ADDR_DELAY, 16'hffff, 16'h0fa0},
      '{aoss_pkg::ADDR_COOL, 16'h1234, 16'h1234}, '{aoss_pkg::ADDR_CTRL, 16'h0001, 16'h0001},
      '{4'hf, 16'hffff, 16'h0000}, '{aoss_pkg::ADDR_REMAIN, 16'hffff, 16'h0000}};
    repeat (4) @(posedge clk);
    chk("engine_rst", 16'h0000, {15'h0000, eng});
    chk("remote_rst", 16'h0000, {15'h0000, remote});
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(aoss_pkg::ADDR_DELAY, d);
    chk("delay_rst", {4'h0, aoss_pkg::DELAY_RST}, d);
    rd_reg(aoss_pkg::ADDR_COOL, d);
    chk("cool_rst", aoss_pkg::COOL_RST_S, d);
    // register rows, saturation of the delay and refused places among them
    foreach (rows[i])
    begin
      wr_reg(rows[i].a, rows[i].w);
      rd_reg(rows[i].a, d);
      chk("reg_row", rows[i].e, d);
    end
    wr_reg(aoss_pkg::ADDR_CTRL, 16'h0000);
    // both warnings off: idle, inhibit contact is closed but ignored
    pins(1'b0, 1'b0);
    st(aoss_pkg::AOSS_AUTO);
    chk("engine_idle", 16'h0000, {15'h0000, eng});
    // pending start with a long delay, then request dropped early
    wr_reg(aoss_pkg::ADDR_DELAY, 16'h0005);
    pins(1'b1, 1'b0);
    st(aoss_pkg::AOSS_DELAY);
    chk("remote_delay", 16'h0000, {15'h0000, remote});
    rd_reg(aoss_pkg::ADDR_REMAIN, d);
    chk("remain", 16'h0005, d);
    pins(1'b0, 1'b0);
    st(aoss_pkg::AOSS_AUTO);
    rd_reg(aoss_pkg::ADDR_REMAIN, d);
    chk("remain_clr", 16'h0000, d);
    // zero delay: remote start at once; warnings held until mains return
    wr_reg(aoss_pkg::ADDR_DELAY, 16'h0000);
    wr_reg(aoss_pkg::ADDR_COOL, 16'h0000);
    pins(1'b1, 1'b0);
    chk("remote_on", 16'h0001, {15'h0000, remote});
    chk("engine_on", 16'h0001, {15'h0000, eng});
    chk("load_inh", 16'h0000, {15'h0000, load_ok});
    pins(1'b1, 1'b1);
    chk("load_ok", 16'h0001, {15'h0000, load_ok});
    pins(1'b0, 1'b0);
    chk("remote_off", 16'h0000, {15'h0000, remote});
    chk("engine_off", 16'h0000, {15'h0000, eng});
    st(aoss_pkg::AOSS_AUTO);
    // start for another cause; inhibit still blocks load on this automatic start
    wr_reg(aoss_pkg::ADDR_CTRL, 16'h0001);
    @(posedge clk);
    cause <= 1'b1;
    repeat (10) @(posedge clk);
    chk("engine_auto", 16'h0001, {15'h0000, eng});
    chk("load_auto", 16'h0000, {15'h0000, load_ok});
    cause <= 1'b0;
    wr_reg(aoss_pkg::ADDR_CTRL, 16'h0000);
    // nonzero cooling: engine keeps running with load off
    wr_reg(aoss_pkg::ADDR_COOL, 16'h0001);
    pins(1'b1, 1'b1);
    pins(1'b0, 1'b0);
    st(aoss_pkg::AOSS_COOL);
    chk("engine_cool", 16'h0001, {15'h0000, eng});
    chk("load_cool", 16'h0000, {15'h0000, load_ok});
    wrap_up();
  end
endmodule // advance_outage_start_sequencer_tb
`default_nettype wire
